// File: design/lltirq_params.svh
// Constants for the line level threshold interrupt block.
`ifndef LLTIRQ_PARAMS_SVH
`define LLTIRQ_PARAMS_SVH
`define LLTIRQ_ADDR_W        8
`define LLTIRQ_DATA_W        8
`define LLTIRQ_OFS_LEVEL     8'h2B
`define LLTIRQ_OFS_CONTROL   8'h2C
`define LLTIRQ_LEVEL_RESET   8'h00
`define LLTIRQ_BIT_FLAG      3
`define LLTIRQ_BIT_SOURCE    2
`define LLTIRQ_BIT_MASK      1
`define LLTIRQ_BIT_DIR       0
`define LLTIRQ_ZERO8         8'h00
`endif

// File: design/lltirq_pkg.sv
// Types shared by the line level threshold interrupt block.
package lltirq_pkg;
    typedef struct packed {
        logic       flag;
        logic       source;
        logic       mask;
        logic       dir;
    } lltirq_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lltirq_req_t;
endpackage : lltirq_pkg

// File: design/lltirq_top.sv
// Line current or voltage threshold monitor with a sticky flag and a masked pin request.
`timescale 1ns/1ps
`include "lltirq_params.svh"

// Operation
// - An 8-bit software-writable threshold level is the comparison level.
// - Source select 0 compares the line current, 1 compares the line voltage.
// - Direction 0 triggers when the absolute measurement falls below the threshold.
// - Direction 1 triggers when the absolute measurement rises above the threshold.
// - A crossing sets the flag at bit 3, which reads 0 while no crossing occurred.
// - The flag stays set until software writes 0 to it.
// - The pin requests an interrupt when flag, mask and global enable are all 1.
// - With the mask at 0 no pin interrupt is produced for a crossing.
module lltirq_top #(
    parameter int MEAS_W = 8
) (
    // Clock, enable and reset.
    input  wire logic               ref_clk,
    input  wire logic               clk_en,
    input  wire logic               rst_b,
    // Register port.
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // Measurements, signed two's complement, and their update strobe.
    input  wire logic [MEAS_W-1:0]  line_current_value,
    input  wire logic [MEAS_W-1:0]  line_voltage_value,
    input  wire logic               meas_update,
    input  wire logic               global_irq_enable,
    // Shared interrupt pin request.
    output logic                    shared_irq_pin
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [MEAS_W-1:0] abs_val(input logic [MEAS_W-1:0] v);
        abs_val = v[MEAS_W-1] ? MEAS_W'(-v) : v;
    endfunction : abs_val

    lltirq_pkg::lltirq_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic wr_level;
    logic wr_ctrl;
    assign wr_level = clk_en && req.wr && (req.addr == `LLTIRQ_OFS_LEVEL);
    assign wr_ctrl  = clk_en && req.wr && (req.addr == `LLTIRQ_OFS_CONTROL);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]               level_q;
    lltirq_pkg::lltirq_ctrl_t ctrl_q;

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            level_q <= `LLTIRQ_LEVEL_RESET;
        end else if (wr_level) begin
            level_q <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q.source <= 1'b0;
            ctrl_q.mask   <= 1'b0;
            ctrl_q.dir    <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q.source <= req.wdata[`LLTIRQ_BIT_SOURCE];
            ctrl_q.mask   <= req.wdata[`LLTIRQ_BIT_MASK];
            ctrl_q.dir    <= req.wdata[`LLTIRQ_BIT_DIR];
        end
    end

    // ------------------------------------------------------------
    // Compare and crossing detection
    // ------------------------------------------------------------
    logic [MEAS_W-1:0] meas_abs;
    logic [MEAS_W-1:0] level_ext;
    logic              cond;
    logic              cond_q;
    logic              crossing;

    assign meas_abs  = abs_val(ctrl_q.source ? line_voltage_value
                                             : line_current_value);
    assign level_ext = MEAS_W'(level_q);
    assign cond      = ctrl_q.dir ? (meas_abs > level_ext)
                                  : (meas_abs < level_ext);
    assign crossing  = clk_en && meas_update && cond && !cond_q;

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cond_q <= 1'b0;
        end else if (clk_en && meas_update) begin
            cond_q <= cond;
        end
    end

    // Set wins over a clear written in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q.flag <= 1'b0;
        end else if (crossing) begin
            ctrl_q.flag <= 1'b1;
        end else if (wr_ctrl && !req.wdata[`LLTIRQ_BIT_FLAG]) begin
            ctrl_q.flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin request and read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shared_irq_pin <= 1'b0;
        end else if (clk_en) begin
            shared_irq_pin <= ctrl_q.flag
                              && ctrl_q.mask
                              && global_irq_enable;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= `LLTIRQ_ZERO8;
        end else if (clk_en) begin
            if (req.rd && req.addr == `LLTIRQ_OFS_LEVEL) begin
                reg_rdata <= level_q;
            end else if (req.rd && req.addr == `LLTIRQ_OFS_CONTROL) begin
                reg_rdata <= {4'h0, ctrl_q};
            end else begin
                reg_rdata <= `LLTIRQ_ZERO8;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_flag_sets: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        crossing |=> ctrl_q.flag)
        else $error("flag not set after crossing");

    chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (ctrl_q.flag && !(wr_ctrl && !req.wdata[`LLTIRQ_BIT_FLAG])) |=> ctrl_q.flag)
        else $error("flag dropped without a clear");

    chk_flag_clears: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (wr_ctrl && !req.wdata[`LLTIRQ_BIT_FLAG] && !crossing) |=> !ctrl_q.flag)
        else $error("flag not cleared by write of zero");

    chk_pin_masked: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && !ctrl_q.mask) |=> !shared_irq_pin)
        else $error("pin raised while masked");

    chk_pin_raise: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && ctrl_q.flag && ctrl_q.mask && global_irq_enable) |=> shared_irq_pin)
        else $error("pin not raised");

    chk_pin_gated: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && !global_irq_enable) |=> !shared_irq_pin)
        else $error("pin raised while globally disabled");

    chk_pin_withdraw: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && !ctrl_q.flag) |=> !shared_irq_pin)
        else $error("pin held without a flag");

    chk_level_write: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        wr_level |=> level_q == $past(reg_wdata))
        else $error("threshold not stored");

    chk_level_read: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && req.rd && req.addr == `LLTIRQ_OFS_LEVEL) |=> reg_rdata == $past(level_q))
        else $error("threshold read back wrong");

    chk_flag_read: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && req.rd && req.addr == `LLTIRQ_OFS_CONTROL)
        |=> reg_rdata[`LLTIRQ_BIT_FLAG] == $past(ctrl_q.flag))
        else $error("flag read back wrong");

    chk_below_trig: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && meas_update && !ctrl_q.dir && !cond_q
         && abs_val(ctrl_q.source ? line_voltage_value : line_current_value) < level_ext)
        |=> ctrl_q.flag)
        else $error("falling crossing missed");

    chk_above_trig: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && meas_update && ctrl_q.dir && !cond_q && ctrl_q.source
         && abs_val(line_voltage_value) > level_ext) |=> ctrl_q.flag)
        else $error("rising crossing missed");

    chk_current_above: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (clk_en && meas_update && ctrl_q.dir && !cond_q && !ctrl_q.source
         && abs_val(line_current_value) > level_ext) |=> ctrl_q.flag)
        else $error("current crossing missed");

    chk_edge_only: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (!ctrl_q.flag && cond_q && !(wr_ctrl && req.wdata[`LLTIRQ_BIT_FLAG])) |=> !ctrl_q.flag
        || $past(crossing))
        else $error("flag set without new crossing");

    chk_freeze_level: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        !clk_en |=> $stable(level_q))
        else $error("threshold moved while frozen");

    chk_freeze_flag: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        !clk_en |=> $stable(ctrl_q.flag) && $stable(shared_irq_pin))
        else $error("flag or pin moved while frozen");

endmodule : lltirq_top

// File: bench/lltirq_host.sv
// Host processor model that counts interrupt requests on the shared pin.
`timescale 1ns/1ps
module lltirq_host (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Interrupt request from the device.
    input  wire logic shared_irq_pin,
    // Requests seen so far.
    output int        irq_seen
);
    logic pin_q;
    // The host services each new request; clearing is done by the bench.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q    <= 1'b0;
            irq_seen <= 0;
        end else begin
            pin_q <= shared_irq_pin;
            if (shared_irq_pin && !pin_q) begin
                irq_seen <= irq_seen + 1;
            end
        end
    end
endmodule : lltirq_host

// File: bench/lltirq_bench.sv
// Self-checking testbench for the line level threshold interrupt block.
`timescale 1ns/1ps
module lltirq_bench;
    logic       ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, meas_update = 0, gie = 0;
    logic       clk_en = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cur = 0, vol = 0;
    logic       pin;
    int         irq_seen, n_errors = 0, n_compared = 0;
    always #10 ref_clk = ~ref_clk;
    lltirq_top lltirq_top_inst (.ref_clk(ref_clk), .clk_en(clk_en), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_current_value(cur), .line_voltage_value(vol),
        .meas_update(meas_update), .global_irq_enable(gie), .shared_irq_pin(pin));
    lltirq_host lltirq_host_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .shared_irq_pin(pin), .irq_seen(irq_seen));
    // -------------------------------------------------------------
    // Bus and compare tasks.
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic count_is(input int exp);
        n_compared++;
        if (irq_seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, irq_seen, exp);
        end
    endtask : count_is
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic upd(input logic [7:0] c, input logic [7:0] v);
        @(posedge ref_clk);
        cur <= c;
        vol <= v;
        meas_update <= 1'b1;
        @(posedge ref_clk);
        meas_update <= 1'b0;
        @(posedge ref_clk);
    endtask : upd
    task automatic set_gie(input logic v);
        @(posedge ref_clk);
        gie <= v;
    endtask : set_gie
    task automatic set_en(input logic v);
        @(posedge ref_clk);
        clk_en <= v;
    endtask : set_en
    task automatic pin_is(input logic exp);
        #1 chk({7'h00, pin}, {7'h00, exp});
    endtask : pin_is
    task automatic give_verdict;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // -------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------
    initial begin
        #100000;
        n_errors++;
        give_verdict();
    end
    task automatic scen_reset_values;
        rd(8'h2B, 8'h00);
        rd(8'h2C, 8'h00);
        rd(8'h2D, 8'h00);
        pin_is(1'b0);
    endtask : scen_reset_values
    task automatic scen_level_rw;
        wr(8'h2B, 8'hA5);
        rd(8'h2B, 8'hA5);
    endtask : scen_level_rw
    task automatic scen_below_crossing;
        wr(8'h2B, 8'h10);
        wr(8'h2C, 8'h0A);
        rd(8'h2C, 8'h02);
        set_gie(1'b1);
        upd(8'h20, 8'h00);
        rd(8'h2C, 8'h02);
        upd(8'hFB, 8'h00);
        rd(8'h2C, 8'h0A);
        pin_is(1'b1);
        count_is(1);
        upd(8'h20, 8'h00);
        rd(8'h2C, 8'h0A);
    endtask : scen_below_crossing
    task automatic scen_mask_and_clear;
        wr(8'h2C, 8'h08);
        repeat (2) @(posedge ref_clk);
        pin_is(1'b0);
        rd(8'h2C, 8'h08);
        wr(8'h2C, 8'h0A);
        repeat (2) @(posedge ref_clk);
        pin_is(1'b1);
        count_is(2);
        set_gie(1'b0);
        repeat (2) @(posedge ref_clk);
        pin_is(1'b0);
        wr(8'h2C, 8'h02);
        set_gie(1'b1);
        repeat (2) @(posedge ref_clk);
        pin_is(1'b0);
        rd(8'h2C, 8'h02);
    endtask : scen_mask_and_clear
    task automatic scen_rearm;
        upd(8'h05, 8'h00);
        rd(8'h2C, 8'h0A);
        pin_is(1'b1);
        count_is(3);
        wr(8'h2C, 8'h02);
        upd(8'h03, 8'h00);
        rd(8'h2C, 8'h02);
        pin_is(1'b0);
    endtask : scen_rearm
    task automatic scen_set_wins;
        upd(8'h20, 8'h00);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h2C;
        reg_wdata <= 8'h02;
        cur <= 8'h05;
        meas_update <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        meas_update <= 1'b0;
        rd(8'h2C, 8'h0A);
        pin_is(1'b1);
        wr(8'h2C, 8'h02);
        rd(8'h2C, 8'h02);
    endtask : scen_set_wins
    task automatic scen_clk_freeze;
        set_en(1'b0);
        wr(8'h2B, 8'h33);
        wr(8'h2C, 8'h05);
        upd(8'h20, 8'h00);
        set_en(1'b1);
        upd(8'h05, 8'h00);
        rd(8'h2B, 8'h10);
        rd(8'h2C, 8'h02);
    endtask : scen_clk_freeze
    task automatic scen_sources;
        wr(8'h2C, 8'h05);
        upd(8'h7F, 8'h00);
        rd(8'h2C, 8'h05);
        upd(8'h00, 8'h90);
        rd(8'h2C, 8'h0D);
        pin_is(1'b0);
        wr(8'h2C, 8'h01);
        upd(8'h08, 8'h90);
        rd(8'h2C, 8'h01);
        upd(8'h80, 8'h00);
        rd(8'h2C, 8'h09);
        count_is(4);
    endtask : scen_sources
    task automatic scen_mid_reset;
        wr(8'h2C, 8'h0B);
        repeat (2) @(posedge ref_clk);
        pin_is(1'b1);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        pin_is(1'b0);
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(8'h2B, 8'h00);
        rd(8'h2C, 8'h00);
        pin_is(1'b0);
        count_is(0);
    endtask : scen_mid_reset
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        scen_reset_values();
        scen_level_rw();
        scen_below_crossing();
        scen_mask_and_clear();
        scen_rearm();
        scen_set_wins();
        scen_clk_freeze();
        scen_sources();
        scen_mid_reset();
        give_verdict();
    end
endmodule : lltirq_bench
